// ### core/rsc_defs.vh
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
// ==========================================
// register map (byte addresses on apb)
`define RSC_OFF_WDOG_SVC 16'h1FF0
`define RSC_OFF_STATUS 16'h1F00
`define RSC_OFF_MASK 16'h1F04
`define RSC_OFF_CTRL 16'h1F08
`define RSC_ADDR_W 16
// ==========================================
// status / mask bit positions
`define RSC_EV_POR 0
`define RSC_EV_PIN 1
`define RSC_EV_WDOG 2
`define RSC_EV_LVR 3
`define RSC_EV_ILL 4
`define RSC_EV_USB 5
`define RSC_EV_W 6
`define RSC_WDOG_CLR_BIT 0
`define RSC_CTRL_USBF 0
// ==========================================
// memory map for fetch check
`define RSC_ROM_LO 16'h1000
`define RSC_ROM_HI 16'h1FFF
`define RSC_RAM_LO 16'h0080
`define RSC_RAM_HI 16'h012F
`define RSC_VEC_HI 16'h1FFE
`define RSC_VEC_LO 16'h1FFF
// ==========================================
// timing
`define RSC_POR_CYCLES 4064
`define RSC_PIN_MIN_CYCLES 4
`define RSC_SE0_MIN_BITS 4
`endif

// ### core/rsc_sync2.v
`timescale 1ns/1ps
// ==========================================
// two-flop level synchroniser
module rsc_sync2 #(
    parameter RST_VAL = 1'b0
) (
    pclk,
    presetn,
    ce,
    d,
    q
);
input wire pclk;
input wire presetn;
input wire ce;
input wire d;
output wire q;
reg meta_r;
reg sync_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        meta_r <= RST_VAL;
        sync_r <= RST_VAL;
    end else if (ce) begin
        meta_r <= d;
        sync_r <= meta_r;
    end
end
assign q = sync_r;
endmodule // rsc_sync2

// ### core/rsc_se0_det.v
`timescale 1ns/1ps
`include "rsc_defs.vh"
// ==========================================
// usb bus-reset detector: se0 held for a number of bit times
module rsc_se0_det #(
    parameter BIT_CYCLES = 2,
    parameter CNT_W = 8
) (
    pclk,
    presetn,
    ce,
    se0,
    bus_reset
);
input wire pclk;
input wire presetn;
input wire ce;
input wire se0;
output reg bus_reset;
reg [CNT_W-1:0] cnt_r;
localparam integer LIMIT_I = BIT_CYCLES * `RSC_SE0_MIN_BITS;
// cut to the counter width on purpose; the limit must fit CNT_W
localparam [CNT_W-1:0] LIMIT = LIMIT_I[CNT_W-1:0];
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt_r <= {CNT_W{1'b0}};
        bus_reset <= 1'b0;
    end else if (ce) begin
        if (!se0) begin
            cnt_r <= {CNT_W{1'b0}};
            bus_reset <= 1'b0;
        end else if (cnt_r < LIMIT) begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end else begin
            bus_reset <= 1'b1;
        end
    end
end
endmodule // rsc_se0_det

// ### core/rsc_ctrl.v
`timescale 1ns/1ps
`include "rsc_defs.vh"
// ==========================================
// Operation
// - six sources reset the device: power, pin, watchdog, low voltage, fetch, usb
// - any reset aborts instruction, initialises control bits, loads reset vector
// - start address from top two bytes; interrupt mask set on exit
// - power-up holds reset 4064 cycles, then waits for pin high
// - after power delay, reset stays while any other source remains
// - pin low keeps internal reset; release only after pin high
// - watchdog, low voltage, illegal fetch drive pin low 3-4 cycles or longer
// - no pulldown while pin already held low from outside
// - power-on reset never drives the pin pulldown
// - se0 for 4-8 bit times sets bus-reset flag and resets
// - watchdog exists only by build option; timeout resets
// - writing one ignored; service register reads all zeros
// - low-voltage detector resets; present only by build option
// - fetch outside program rom, except ram, causes illegal-address reset
// - fetches inside data ram are always legal
module rsc_ctrl #(
    parameter WDOG_EN = 1,
    parameter LVR_EN = 1,
    parameter POR_CYCLES = `RSC_POR_CYCLES,
    parameter WDOG_CYCLES = 65536,
    parameter USB_BIT_CYCLES = 2,
    parameter CNT_W = 17
) (
    pclk,
    presetn,
    ce,
    osc_running,
    rst_pin_in,
    rst_pin_out,
    rst_pin_oe_n,
    low_voltage,
    usb_se0,
    fetch_valid,
    fetch_addr,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    sys_reset,
    cpu_set_imask,
    reset_vec_hi,
    reset_vec_lo,
    irq
);
input wire pclk;
input wire presetn;
input wire ce;
input wire osc_running;
input wire rst_pin_in;
output wire rst_pin_out;
output wire rst_pin_oe_n;
input wire low_voltage;
input wire usb_se0;
input wire fetch_valid;
input wire [15:0] fetch_addr;
input wire psel;
input wire penable;
input wire pwrite;
input wire [15:0] paddr;
input wire [31:0] pwdata;
output reg [31:0] prdata;
output wire pready;
output wire pslverr;
output reg sys_reset;
output reg cpu_set_imask;
output wire [15:0] reset_vec_hi;
output wire [15:0] reset_vec_lo;
output wire irq;

// ==========================================
// input synchronisers
wire osc_s;
wire pin_s;
wire lv_s;
wire se0_s;
rsc_sync2 #(.RST_VAL(1'b0)) u_sync_osc (.pclk(pclk), .presetn(presetn), .ce(ce),
    .d(osc_running), .q(osc_s));
rsc_sync2 #(.RST_VAL(1'b0)) u_sync_pin (.pclk(pclk), .presetn(presetn), .ce(ce),
    .d(rst_pin_in), .q(pin_s));
rsc_sync2 #(.RST_VAL(1'b0)) u_sync_lv (.pclk(pclk), .presetn(presetn), .ce(ce),
    .d(low_voltage), .q(lv_s));
rsc_sync2 #(.RST_VAL(1'b0)) u_sync_se0 (.pclk(pclk), .presetn(presetn), .ce(ce),
    .d(usb_se0), .q(se0_s));

// ==========================================
// usb bus reset
wire usb_rst;
rsc_se0_det #(.BIT_CYCLES(USB_BIT_CYCLES), .CNT_W(8)) u_se0 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .se0(se0_s),
    .bus_reset(usb_rst)
);

// ==========================================
// helpers
function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
        in_range = (a >= lo) && (a <= hi);
    end
endfunction

// ==========================================
// apb decode
wire apb_acc = psel & penable;
wire apb_wr = apb_acc & pwrite;
wire hit_wdog = (paddr == `RSC_OFF_WDOG_SVC);
wire hit_stat = (paddr == `RSC_OFF_STATUS);
wire hit_mask = (paddr == `RSC_OFF_MASK);
wire hit_ctrl = (paddr == `RSC_OFF_CTRL);
wire hit_any = hit_wdog | hit_stat | hit_mask | hit_ctrl;
assign pready = 1'b1;
assign pslverr = apb_acc & ~hit_any;

// ==========================================
// power-on delay: flops under presetn model the power-up
reg [12:0] por_cnt_r;
reg por_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        por_cnt_r <= 13'h0000;
        por_r <= 1'b1;
    end else if (ce && osc_s && por_r) begin
        if (por_cnt_r == POR_CYCLES - 1)
            por_r <= 1'b0;
        else
            por_cnt_r <= por_cnt_r + 13'h0001;
    end
end

// ==========================================
// watchdog timer
reg [CNT_W-1:0] wd_cnt_r;
reg wd_to_r;
wire wd_kick = apb_wr & hit_wdog & ~pwdata[`RSC_WDOG_CLR_BIT];
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wd_cnt_r <= {CNT_W{1'b0}};
        wd_to_r <= 1'b0;
    end else if (ce) begin
        if (sys_reset || wd_kick || WDOG_EN == 0) begin
            wd_cnt_r <= {CNT_W{1'b0}};
            wd_to_r <= 1'b0;
        end else if (wd_cnt_r == WDOG_CYCLES - 1) begin
            wd_to_r <= 1'b1;
        end else begin
            wd_cnt_r <= wd_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

// ==========================================
// illegal fetch
reg ill_r;
wire fetch_ok = in_range(fetch_addr, `RSC_ROM_LO, `RSC_ROM_HI) |
    in_range(fetch_addr, `RSC_RAM_LO, `RSC_RAM_HI);
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        ill_r <= 1'b0;
    else if (ce)
        ill_r <= fetch_valid & ~fetch_ok & ~sys_reset;
end

wire lvr_src = lv_s & (LVR_EN != 0);
// pin-driving internal sources; power-on deliberately excluded
wire drv_src = wd_to_r | lvr_src | ill_r;

// ==========================================
// pulldown stretcher
reg [2:0] pd_cnt_r;
reg pd_r;
reg pd_ext_r;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pd_cnt_r <= 3'h0;
        pd_r <= 1'b0;
        pd_ext_r <= 1'b0;
    end else if (ce) begin
        // pin low while we are not pulling means outside drive
        pd_ext_r <= ~pin_s & ~pd_r;
        if (drv_src && !pd_r && (pin_s || !pd_ext_r)) begin
            pd_r <= ~pd_ext_r;
            pd_cnt_r <= 3'h0;
        end else if (pd_r) begin
            if (pd_cnt_r < `RSC_PIN_MIN_CYCLES - 1)
                pd_cnt_r <= pd_cnt_r + 3'h1;
            else if (!drv_src)
                pd_r <= 1'b0;
        end
    end
end
assign rst_pin_out = 1'b0;
assign rst_pin_oe_n = ~pd_r;

// ==========================================
// internal reset merge
wire any_src = por_r | ~pin_s | drv_src | usb_rst;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sys_reset <= 1'b1;
        cpu_set_imask <= 1'b0;
    end else if (ce) begin
        sys_reset <= any_src | pd_r;
        cpu_set_imask <= sys_reset & ~(any_src | pd_r);
    end
end
assign reset_vec_hi = `RSC_VEC_HI;
assign reset_vec_lo = `RSC_VEC_LO;

// ==========================================
// status, mask, bus-reset flag
reg [`RSC_EV_W-1:0] stat_r;
reg [`RSC_EV_W-1:0] mask_r;
reg usbf_r;
wire [`RSC_EV_W-1:0] ev = {usb_rst, ill_r, lvr_src, wd_to_r, ~pin_s, por_r};
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        stat_r <= 6'h00;
        mask_r <= 6'h00;
        usbf_r <= 1'b0;
    end else if (ce) begin
        if (apb_wr && hit_stat)
            stat_r <= (stat_r & ~pwdata[`RSC_EV_W-1:0]) | ev;
        else
            stat_r <= stat_r | ev;
        if (apb_wr && hit_mask)
            mask_r <= pwdata[`RSC_EV_W-1:0];
        if (usb_rst)
            usbf_r <= 1'b1;
        else if (apb_wr && hit_ctrl && pwdata[`RSC_CTRL_USBF])
            usbf_r <= 1'b0;
    end
end
assign irq = |(stat_r & mask_r);

always @* begin
    prdata = 32'h00000000;
    if (hit_stat)
        prdata = {26'h0000000, stat_r};
    else if (hit_mask)
        prdata = {26'h0000000, mask_r};
    else if (hit_ctrl)
        prdata = {31'h00000000, usbf_r};
end
endmodule // rsc_ctrl

// ### sim/rsc_ctrl_props.sv
`timescale 1ns/1ps
// ==========================================
// port checks of the reset controller
module rsc_ctrl_props (
    input wire pclk,
    input wire presetn,
    input wire rst_pin_in,
    input wire rst_pin_out,
    input wire rst_pin_oe_n,
    input wire low_voltage,
    input wire fetch_valid,
    input wire [15:0] fetch_addr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sys_reset,
    input wire cpu_set_imask,
    input wire [15:0] reset_vec_hi,
    input wire [15:0] reset_vec_lo
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
wire rom = fetch_addr >= 16'h1000 && fetch_addr <= 16'h1FFF;
wire ill = fetch_valid && !rom && !(fetch_addr >= 16'h0080 && fetch_addr <= 16'h012F);
wire acc = psel && penable;
wire mapped = paddr == 16'h1F00 || paddr == 16'h1F04 || paddr == 16'h1F08 || paddr == 16'h1FF0;
property p_ill_rst; ill && rst_pin_in |-> ##[1:4] sys_reset; endproperty
a_ill_rst: assert property (p_ill_rst) else $error("no reset on bad fetch");
property p_ill_pull; ill && rst_pin_in && rst_pin_oe_n |-> ##[1:3] !rst_pin_oe_n; endproperty
a_ill_pull: assert property (p_ill_pull) else $error("no pin pull on bad fetch");
property p_ok_fetch;
    fetch_valid && !ill && !sys_reset && rst_pin_in && !low_voltage |=> !sys_reset[*3];
endproperty
a_ok_fetch: assert property (p_ok_fetch) else $error("reset on legal fetch");
property p_pull_len; $fell(rst_pin_oe_n) |-> !rst_pin_oe_n[*4]; endproperty
a_pull_len: assert property (p_pull_len) else $error("pin pull too short");
property p_od; !rst_pin_out; endproperty
a_od: assert property (p_od) else $error("pin driven high");
property p_no_ext; (!rst_pin_in && rst_pin_oe_n)[*3] |=> rst_pin_oe_n; endproperty
a_no_ext: assert property (p_no_ext) else $error("pull while pin held low");
property p_pin_rst; (!rst_pin_in)[*5] |-> sys_reset; endproperty
a_pin_rst: assert property (p_pin_rst) else $error("pin low without reset");
property p_lvr; $rose(low_voltage) |-> ##[1:5] sys_reset; endproperty
a_lvr: assert property (p_lvr) else $error("no reset on low supply");
property p_imask; $fell(sys_reset) |-> ##[0:1] cpu_set_imask; endproperty
a_imask: assert property (p_imask) else $error("mask not set at release");
property p_vec; reset_vec_hi == 16'h1FFE && reset_vec_lo == 16'h1FFF; endproperty
a_vec: assert property (p_vec) else $error("vector address wrong");
property p_rdz; acc && !pwrite && paddr == 16'h1FF0 |-> prdata == 32'h0; endproperty
a_rdz: assert property (p_rdz) else $error("service reg read nonzero");
property p_err; acc |-> pready && pslverr == !mapped; endproperty
a_err: assert property (p_err) else $error("bad bus response");
endmodule // rsc_ctrl_props

// ### sim/rsc_ext.sv
`timescale 1ns/1ps
// ==========================================
// pin circuitry with pull-up and usb host
module rsc_ext (
    input wire pclk,
    input wire oe_n,
    input wire hold_low,
    input wire se0_req,
    output logic pin,
    output logic se0
);
// pull-up returns the wire high once nobody pulls
assign pin = !(hold_low || !oe_n);
always @(posedge pclk) se0 <= se0_req;
endmodule // rsc_ext

// ### sim/reset_source_controller_tb.sv
`timescale 1ns/1ps
module reset_source_controller_tb;
logic pclk, presetn, ce, osc_running, hold_low, se0_req, low_voltage, fetch_valid;
logic psel, penable, pwrite, e_s;
logic [15:0] fetch_addr, paddr;
logic [31:0] pwdata, q;
wire pin, oe_n, se0, pin_out, pready, pslverr, sys_reset, imask, irq;
wire [31:0] prdata;
wire [15:0] vec_hi, vec_lo;
int fail_count, n_tests, i, k, d, pulls, p0;
logic [15:0] fa [8] = '{16'h007F, 16'h0080, 16'h012F, 16'h0130,
                        16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000};
logic [7:0] leg = 8'h66;
rsc_ctrl #(.POR_CYCLES(16), .WDOG_CYCLES(64), .USB_BIT_CYCLES(2)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .osc_running(osc_running),
    .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n),
    .low_voltage(low_voltage), .usb_se0(se0), .fetch_valid(fetch_valid),
    .fetch_addr(fetch_addr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sys_reset(sys_reset), .cpu_set_imask(imask),
    .reset_vec_hi(vec_hi), .reset_vec_lo(vec_lo), .irq(irq));
rsc_ext u_ext (.pclk(pclk), .oe_n(oe_n), .hold_low(hold_low), .se0_req(se0_req),
    .pin(pin), .se0(se0));
// ==========================================
// tasks
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
        fail_count++;
        $display("[FAIL] %s exp %h got %h", n, e, g);
    end
endtask
task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic wait_sr(input logic v);
    for (k = 0; k < 300 && sys_reset !== v; k++) @(posedge pclk);
    chk("sys_reset", v, sys_reset);
endtask
// mask is rewritten each time since other tests change it; an internal reset leaves it
task automatic ev(input int b, input logic wt);
    if (wt) wait_sr(1);
    wait_sr(0);
    apb(1, 16'h1F04, 32'h3F);
    apb(0, 16'h1F00, 0);
    chk("status", 32'h1 << b, q & (32'h1 << b));
    chk("irq", 1, irq);
    apb(1, 16'h1F00, 32'h3F);
    apb(1, 16'h1FF0, 0);
    chk("irq_clr", 0, irq);
endtask
task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
// ==========================================
// clock, watchdog, tests
initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
end
always @(posedge pclk) if (oe_n === 1'b0) pulls++;
initial begin
    #400000;
    fail_count++;
    complete_run();
end
initial begin
    {presetn, psel, penable, pwrite, fetch_valid, low_voltage, se0_req, hold_low} = 0;
    {ce, osc_running} = 2'b11;
    {paddr, pwdata, fetch_addr} = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    wait_sr(0);
    chk("por_len", 1, k >= 16 && k <= 22);
    chk("por_pull", 0, pulls);
    ev(0, 0);
    apb(0, 16'h1F0C, 0);
    chk("unmapped", 32'h1, {q[30:0], e_s});
    apb(1, 16'h1FF0, 32'hFF);
    apb(0, 16'h1FF0, 0);
    chk("svc_read", 0, q);
    for (i = 0; i < 8; i++) begin
        fetch_valid <= 1'b1;
        fetch_addr <= fa[i];
        @(posedge pclk);
        fetch_valid <= 1'b0;
        if (leg[i]) begin
            repeat (6) @(posedge pclk);
            chk("legal_fetch", 0, sys_reset);
        end else ev(4, 1);
    end
    se0_req <= 1'b1;
    repeat (6) @(posedge pclk);
    se0_req <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("short_se0", 0, sys_reset);
    se0_req <= 1'b1;
    repeat (20) @(posedge pclk);
    se0_req <= 1'b0;
    ev(5, 1);
    apb(0, 16'h1F08, 0);
    chk("usb_flag", 1, q[0]);
    apb(1, 16'h1F08, 1);
    apb(0, 16'h1F08, 0);
    chk("usb_clr", 0, q[0]);
    low_voltage <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("lvr_hold", 1, sys_reset);
    low_voltage <= 1'b0;
    wait_sr(0);
    apb(1, 16'h1F04, 0);
    chk("masked", 0, irq);
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    apb(1, 16'h1F04, 32'h3F);
    ce <= 1'b1;
    apb(0, 16'h1F04, 0);
    chk("ce_hold", 0, q);
    ev(3, 0);
    for (d = 0; d < 2; d++) begin
        p0 = pulls;
        repeat (5) begin
            repeat (20) @(posedge pclk);
            apb(1, 16'h1FF0, d);
        end
        wait_sr(0);
        apb(0, 16'h1F00, 0);
        chk("wdog", d, q[2]);
        chk("wdog_pull", d, pulls > p0);
        apb(1, 16'h1F00, 32'h3F);
    end
    presetn <= 1'b0;
    hold_low <= 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("pin_hold", 1, sys_reset);
    chk("no_pull", 1, oe_n);
    hold_low <= 1'b0;
    ev(1, 1);
    complete_run();
end
endmodule // reset_source_controller_tb
bind rsc_ctrl rsc_ctrl_props u_props (.*);
